// ===== inc/pol_pkg.sv
package pol_pkg;
  // ----------------------------------------------------------------
  // widths and scales
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [9:0] PCT_FULL = 10'h3e8; // 100.0 percent in 0.1 % units
  localparam logic [10:0] CUR_MAX = 11'h4b0; // 120.0 percent of rated current
  localparam logic [10:0] CUR_MIN = 11'h064; // 10.0 percent of rated current
  localparam logic [9:0] TIME_MAX = 10'h3e7; // 99.9 s in 0.1 s units
  localparam logic [9:0] HB_MAX = 10'h064; // 100 percent
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 100000; // control period 100 us
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int SU_UNIT_NS = 100000000; // start-up time unit 0.1 s
  localparam int SU_UNIT_TICKS = SU_UNIT_NS / TICK_NS;
  localparam logic [19:0] SLEW_PER_UNIT = 20'h003e8; // ticks per 0.1 s of slew time
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_RAMP_LO = 5'h01;
  localparam logic [4:0] OFS_RAMP_HI = 5'h02;
  localparam logic [4:0] OFS_RAMP_SRC = 5'h03;
  localparam logic [4:0] OFS_SLOW_UP = 5'h04;
  localparam logic [4:0] OFS_SLOW_DN = 5'h05;
  localparam logic [4:0] OFS_CUR_LIM = 5'h06;
  localparam logic [4:0] OFS_CUR_SRC = 5'h07;
  localparam logic [4:0] OFS_HB_THR = 5'h08;
  localparam logic [4:0] OFS_DO1 = 5'h09;
  localparam logic [4:0] OFS_DO2 = 5'h0a;
  localparam logic [4:0] OFS_SU_LIM = 5'h0b;
  localparam logic [4:0] OFS_SU_TIME = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_LEVEL = 5'h11;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_AUX_EN = 0;
  localparam int CTRL_SU_EN = 1;
  localparam int CTRL_ZVS = 2;
  localparam int CTRL_KEY_MAN = 3;
  localparam int CTRL_DI_LSB = 4;
  localparam int SRC_HI_LSB = 2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [9:0] RST_RAMP_LO = 10'h000;
  localparam logic [9:0] RST_RAMP_HI = 10'h3e8;
  localparam logic [9:0] RST_SLOW = 10'h00a;
  localparam logic [10:0] RST_CUR_LIM = 11'h3e8;
  localparam logic [9:0] RST_HB_THR = 10'h000;
  localparam logic [9:0] RST_SU_LIM = 10'h3e8;
  localparam logic [9:0] RST_SU_TIME = 10'h000;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_KEY = 2'h0, SRC_ADJ1 = 2'h1, SRC_ADJ2 = 2'h2, SRC_ADJ3 = 2'h3
  } pol_src_t;
  typedef enum logic [1:0] {
    DI_NONE = 2'h0, DI_ON = 2'h1, DI_OFF = 2'h2
  } pol_di_t;
  typedef enum logic [1:0] {
    DO_NONE = 2'h0, DO_STANDBY = 2'h1, DO_OPERATING = 2'h2, DO_HB = 2'h3
  } pol_do_t;
endpackage

// ===== tb/pol_top_props.sv
// ----------------------------------------------------------------
// port checker for the output shaping block
// ----------------------------------------------------------------
module pol_top_props (
  // clock and reset
  input logic clk_sys,
  input logic rst,
  // watched ports
  input logic reg_rd,
  input logic [15:0] reg_rdata,
  input logic run_cmd,
  input logic [9:0] out_level,
  input logic hb_alarm,
  input logic cur_limit_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [9:0] lvl_q;
  logic [9:0] gap_cnt;
  // cycles since the output last moved, saturating
  always_ff @(posedge clk_sys) begin
    lvl_q <= out_level;
    if (rst || out_level != lvl_q) begin
      gap_cnt <= 10'h000;
    end else if (gap_cnt != 10'h3ff) begin
      gap_cnt <= gap_cnt + 10'h001;
    end
  end
  sequence lvl_step;
    out_level != lvl_q;
  endsequence
  sequence lvl_held;
    $stable(out_level) [*8];
  endsequence
  AST_RD_IDLE:
    assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("read data not idle");
  AST_LEVEL_RANGE:
    assert property (out_level <= 10'h3e8) else $error("output above full scale");
  AST_STEP_GAP:
    assert property (lvl_step |-> gap_cnt >= 10'h3e7) else $error("output moved between ticks");
  AST_STEP_HOLD:
    assert property (lvl_step |=> lvl_held) else $error("output not held after a step");
  AST_STANDBY_NO_RISE:
    assert property (!run_cmd [*4] |-> out_level <= $past(out_level)) else $error("rise in standby");
  AST_REST_ZERO:
    assert property (!run_cmd && out_level == 10'h000 |=> out_level == 10'h000)
      else $error("output left zero in standby");
  AST_HB_STANDBY:
    assert property (!run_cmd [*3] |-> !hb_alarm) else $error("alarm in standby");
  AST_LIMIT_NO_RISE:
    assert property (cur_limit_active [*8] |-> out_level <= $past(out_level, 4))
      else $error("output rose while limiting");
endmodule // pol_top_props

bind pol_top pol_top_props pol_top_props_inst (.clk_sys(clk_sys), .rst(rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .run_cmd(run_cmd), .out_level(out_level), .hb_alarm(hb_alarm),
  .cur_limit_active(cur_limit_active));

// ===== tb/pol_top_test.sv
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module pol_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst, reg_wr, reg_rd, run_cmd, di, cur_act, hb, man, do1, do2;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv, start;
  logic [9:0] demand, adj, load_ratio, out_level;
  logic [10:0] load_current;
  int mismatches, total_checks;
  pol_top pol_top_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .run_cmd(run_cmd), .demand(demand), .aux_in(adj), .first_external_adjuster(adj),
    .second_external_adjuster(adj), .third_external_adjuster(adj),
    .load_current(load_current), .load_ratio(load_ratio), .first_digital_input(di),
    .out_level(out_level), .cur_limit_active(cur_act), .hb_alarm(hb), .manual_active(man),
    .first_digital_output(do1), .second_digital_output(do2));
  // ----------------------------------------------------------------
  // clock, closing and register port tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task end_of_test();
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rdc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rv = reg_rdata;
    `CHK("reg_rdata", e, rv & m)
  endtask
  // refused write raises the sticky flag; accepted one reads back
  task bad(input logic [4:0] a, input logic [15:0] d);
    wr(a, d);
    rdc(pol_pkg::OFS_STATUS, 16'h0020, 16'h0020);
  endtask
  task ok(input logic [4:0] a, input logic [15:0] d);
    wr(a, d);
    rdc(a, 16'hffff, d);
  endtask
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, reg_wr, reg_rd, run_cmd, di, reg_addr, reg_wdata} = '0;
    {demand, adj, load_ratio, load_current} = {10'h3e8, 10'h1f4, 10'h064, 11'h000};
    mismatches = 0;
    total_checks = 0;
    rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(pol_pkg::OFS_RAMP_HI, 16'hffff, 16'h03e8);
    rdc(pol_pkg::OFS_SLOW_UP, 16'hffff, 16'h000a);
    rdc(pol_pkg::OFS_SLOW_DN, 16'hffff, 16'h000a);
    rdc(pol_pkg::OFS_CUR_LIM, 16'hffff, 16'h03e8);
    rdc(pol_pkg::OFS_DO2, 16'hffff, 16'h0000);
    rdc(5'h1f, 16'hffff, 16'h0000);
    bad(pol_pkg::OFS_RAMP_HI, 16'h0000);
    bad(pol_pkg::OFS_RAMP_HI, 16'h03e9);
    ok(pol_pkg::OFS_RAMP_HI, 16'h0001);
    ok(pol_pkg::OFS_RAMP_HI, 16'h01f4);
    ok(pol_pkg::OFS_RAMP_LO, 16'h01f4);
    bad(pol_pkg::OFS_RAMP_HI, 16'h01f3);
    ok(pol_pkg::OFS_RAMP_LO, 16'h0000);
    ok(pol_pkg::OFS_RAMP_HI, 16'h03e8);
    bad(pol_pkg::OFS_RAMP_SRC, 16'h0005);
    ok(pol_pkg::OFS_RAMP_SRC, 16'h0001);
    bad(pol_pkg::OFS_RAMP_SRC, 16'h0002);
    ok(pol_pkg::OFS_CUR_LIM, 16'h0000);
    bad(pol_pkg::OFS_CUR_SRC, 16'h0001);
    ok(pol_pkg::OFS_RAMP_SRC, 16'h0000);
    bad(pol_pkg::OFS_CUR_LIM, 16'h0063);
    bad(pol_pkg::OFS_CUR_LIM, 16'h04b1);
    ok(pol_pkg::OFS_CUR_LIM, 16'h04b0);
    di <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      ok(pol_pkg::OFS_CTRL, 16'(m << 4));
      repeat (5) @(posedge clk_sys);
      `CHK("manual_active", 1'(m == 1), man)
    end
    ok(pol_pkg::OFS_CTRL, 16'h0018);
    repeat (5) @(posedge clk_sys);
    `CHK("manual_active", 1'b0, man)
    ok(pol_pkg::OFS_CTRL, 16'h0000);
    run_cmd <= 1'b1;
    ok(pol_pkg::OFS_HB_THR, 16'h0032);
    repeat (5) @(posedge clk_sys);
    `CHK("hb_alarm", 1'b1, hb)
    for (int d = 0; d < 4; d++) begin
      ok(pol_pkg::OFS_DO1, 16'(d));
      repeat (5) @(posedge clk_sys);
      `CHK("first_digital_output", 1'(d >= 2), do1)
    end
    ok(pol_pkg::OFS_DO2, 16'h0002);
    repeat (5) @(posedge clk_sys);
    `CHK("second_digital_output", 1'b1, do2)
    // zero slew times: targets are adopted at the next control tick
    ok(pol_pkg::OFS_SLOW_UP, 16'h0000);
    ok(pol_pkg::OFS_SLOW_DN, 16'h0000);
    ok(pol_pkg::OFS_CTRL, 16'h0001);
    repeat (2500) @(posedge clk_sys);
    rdc(pol_pkg::OFS_LEVEL, 16'hffff, 16'h01f4);
    ok(pol_pkg::OFS_RAMP_HI, 16'h0190);
    repeat (2500) @(posedge clk_sys);
    rdc(pol_pkg::OFS_LEVEL, 16'hffff, 16'h0190);
    ok(pol_pkg::OFS_RAMP_HI, 16'h03e8);
    ok(pol_pkg::OFS_SU_LIM, 16'h00c8);
    ok(pol_pkg::OFS_SU_TIME, 16'h0005);
    ok(pol_pkg::OFS_CTRL, 16'h0003);
    repeat (2500) @(posedge clk_sys);
    rdc(pol_pkg::OFS_LEVEL, 16'hffff, 16'h00c8);
    // adjuster limit is 100 + 500 * 900 / 1000 = 550
    ok(pol_pkg::OFS_CUR_LIM, 16'h0000);
    ok(pol_pkg::OFS_CUR_SRC, 16'h0001);
    load_current <= 11'h227;
    repeat (5) @(posedge clk_sys);
    `CHK("cur_limit_active", 1'b1, cur_act)
    load_current <= 11'h225;
    repeat (5) @(posedge clk_sys);
    `CHK("cur_limit_active", 1'b0, cur_act)
    ok(pol_pkg::OFS_CUR_SRC, 16'h0000);
    load_current <= 11'h000;
    // 0.1 s full scale: one unit per control tick
    ok(pol_pkg::OFS_SLOW_UP, 16'h0001);
    ok(pol_pkg::OFS_CTRL, 16'h0000);
    rdc(pol_pkg::OFS_LEVEL, 16'hfc00, 16'h0000);
    start = rv;
    repeat (40000) @(posedge clk_sys);
    rdc(pol_pkg::OFS_LEVEL, 16'hfc00, 16'h0000);
    `CHK("rise", 1'b1, (rv - start) inside {[39:41]})
    ok(pol_pkg::OFS_SLOW_DN, 16'h0001);
    ok(pol_pkg::OFS_CUR_LIM, 16'h0064);
    run_cmd <= 1'b0;
    load_current <= 11'h7ff;
    rdc(pol_pkg::OFS_LEVEL, 16'hfc00, 16'h0000);
    start = rv;
    repeat (20000) @(posedge clk_sys);
    rdc(pol_pkg::OFS_LEVEL, 16'hfc00, 16'h0000);
    `CHK("fall", 1'b1, (start - rv) inside {[19:21]})
    `CHK("cur_limit_active", 1'b1, cur_act)
    ok(pol_pkg::OFS_CTRL, 16'h0004);
    repeat (5) @(posedge clk_sys);
    `CHK("cur_limit_active", 1'b0, cur_act)
    end_of_test();
  end
  // watchdog against a hung sequence
  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end
endmodule // pol_top_test

// ===== verilog/pol_slew.sv
// ------------------------------------------------------------------
// slew limiter: one 0.1 % step at most per control tick, or a jump to target when the slew time is zero
// ------------------------------------------------------------------
module pol_slew (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control period enable
  input wire logic tick,
  // target and slew times in 0.1 s
  input wire logic [9:0] target,
  input wire logic [9:0] up_time,
  input wire logic [9:0] dn_time,
  // limited output
  output logic [9:0] level
);
  logic [19:0] acc_reg;
  logic [19:0] span_up;
  logic [19:0] span_dn;
  logic [19:0] acc_sum;

  // ticks needed for a full-scale swing, in accumulator units
  assign span_up = 20'(up_time * pol_pkg::SLEW_PER_UNIT);
  assign span_dn = 20'(dn_time * pol_pkg::SLEW_PER_UNIT);
  assign acc_sum = acc_reg + 20'(pol_pkg::PCT_FULL);

  // bresenham stepping so a full swing lasts exactly the set time
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level <= 10'h000;
      acc_reg <= 20'h00000;
    end else if (tick) begin
      if (target > level) begin
        if (up_time == 10'h000) begin
          level <= target;
          acc_reg <= 20'h00000;
        end else if (acc_sum >= span_up) begin
          level <= level + 10'h001;
          acc_reg <= acc_sum - span_up;
        end else begin
          acc_reg <= acc_sum;
        end
      end else if (target < level) begin
        if (dn_time == 10'h000) begin
          level <= target;
          acc_reg <= 20'h00000;
        end else if (acc_sum >= span_dn) begin
          level <= level - 10'h001;
          acc_reg <= acc_sum - span_dn;
        end else begin
          acc_reg <= acc_sum;
        end
      end else begin
        acc_reg <= 20'h00000;
      end
    end
  end
endmodule // pol_slew

// ===== verilog/pol_top.sv
module pol_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // process inputs, same clock domain, 0.1 % units
  input wire logic run_cmd,
  input wire logic [9:0] demand,
  input wire logic [9:0] aux_in,
  input wire logic [9:0] first_external_adjuster,
  input wire logic [9:0] second_external_adjuster,
  input wire logic [9:0] third_external_adjuster,
  input wire logic [10:0] load_current,
  input wire logic [9:0] load_ratio,
  // pin
  input wire logic first_digital_input,
  // outputs
  output logic [9:0] out_level,
  output logic cur_limit_active,
  output logic hb_alarm,
  output logic manual_active,
  output logic first_digital_output,
  output logic second_digital_output
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // scale a percentage by a factor given as 0 to 100.0 percent
  function automatic logic [9:0] pct_mul(input logic [9:0] a, input logic [9:0] b);
    logic [19:0] prod;
    prod = 20'(a) * 20'(b);
    return 10'(prod / 20'(pol_pkg::PCT_FULL));
  endfunction

  // pick one of the three adjusters
  function automatic logic [9:0] adj_pick(input logic [1:0] src, input logic [9:0] a1,
                                          input logic [9:0] a2, input logic [9:0] a3);
    case (src)
      pol_pkg::SRC_ADJ1: return a1;
      pol_pkg::SRC_ADJ2: return a2;
      pol_pkg::SRC_ADJ3: return a3;
      default: return pol_pkg::PCT_FULL;
    endcase
  endfunction

  // digital output function selection
  function automatic logic do_pick(input logic [1:0] fn, input logic run, input logic hb);
    case (fn)
      pol_pkg::DO_STANDBY: return ~run;
      pol_pkg::DO_OPERATING: return run;
      pol_pkg::DO_HB: return hb;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [9:0] ramp_lo_reg;
  logic [9:0] ramp_hi_reg;
  logic [1:0] lo_src_reg;
  logic [1:0] hi_src_reg;
  logic [9:0] slow_up_reg;
  logic [9:0] slow_dn_reg;
  logic [10:0] cur_lim_reg;
  logic [1:0] cur_src_reg;
  logic [9:0] hb_thr_reg;
  logic [1:0] do1_reg;
  logic [1:0] do2_reg;
  logic [9:0] su_lim_reg;
  logic [9:0] su_time_reg;
  logic reject_reg;
  logic di_meta_reg;
  logic di_sync_reg;
  logic [9:0] tick_cnt_reg;
  logic tick_reg;
  logic [9:0] su_div_reg;
  logic [9:0] su_elapsed_reg;
  logic su_active_reg;
  logic [9:0] target;
  logic [9:0] slew_level;
  logic [9:0] lo_eff;
  logic [9:0] hi_eff;
  logic [10:0] lim_eff;
  logic lim_on;
  logic over_lim;
  logic manual_now;
  logic hb_now;
  logic wr_bad;
  logic [1:0] new_lo;
  logic [1:0] new_hi;
  logic [1:0] new_cur;
  logic [1:0] di_mode;

  assign di_mode = ctrl_reg[pol_pkg::CTRL_DI_LSB +: 2];
  assign new_lo = reg_wdata[1:0];
  assign new_hi = reg_wdata[pol_pkg::SRC_HI_LSB +: 2];
  assign new_cur = reg_wdata[1:0];

  // ----------------------------------------------------------------
  // pin synchroniser and control tick
  // ----------------------------------------------------------------
  // two flops before the digital input is looked at
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      di_meta_reg <= 1'b0;
      di_sync_reg <= 1'b0;
    end else begin
      di_meta_reg <= first_digital_input;
      di_sync_reg <= di_meta_reg;
    end
  end

  // control period enable pulse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt_reg <= 10'h000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == 10'(pol_pkg::TICK_CYC - 1)) begin
      tick_cnt_reg <= 10'h000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 10'h001;
      tick_reg <= 1'b0;
    end
  end

  // start-up timer in 0.1 s units, counting only while elapsed units stay below su_time_reg
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      su_div_reg <= 10'h000;
      su_elapsed_reg <= 10'h000;
      su_active_reg <= 1'b1;
    end else begin
      su_active_reg <= su_elapsed_reg < su_time_reg;
      if (tick_reg && su_active_reg) begin
        if (su_div_reg == 10'(pol_pkg::SU_UNIT_TICKS - 1)) begin
          su_div_reg <= 10'h000;
          su_elapsed_reg <= su_elapsed_reg + 10'h001;
        end else begin
          su_div_reg <= su_div_reg + 10'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // write checks
  // ----------------------------------------------------------------
  // flags writes that would break a range or an allocation
  always_comb begin
    wr_bad = 1'b0;
    case (reg_addr)
      pol_pkg::OFS_RAMP_LO: wr_bad = reg_wdata > 16'(ramp_hi_reg) ||
                                     reg_wdata >= 16'(pol_pkg::PCT_FULL);
      pol_pkg::OFS_RAMP_HI: wr_bad = reg_wdata == 16'h0000 ||
                                     reg_wdata > 16'(pol_pkg::PCT_FULL) ||
                                     reg_wdata < 16'(ramp_lo_reg);
      pol_pkg::OFS_RAMP_SRC: wr_bad = new_lo == pol_pkg::SRC_ADJ3 ||
                                      new_hi == pol_pkg::SRC_ADJ3 ||
                                      (new_lo != pol_pkg::SRC_KEY && new_lo == new_hi) ||
                                      (lo_src_reg != pol_pkg::SRC_KEY &&
                                       new_lo != pol_pkg::SRC_KEY && new_lo != lo_src_reg) ||
                                      (hi_src_reg != pol_pkg::SRC_KEY &&
                                       new_hi != pol_pkg::SRC_KEY && new_hi != hi_src_reg) ||
                                      (cur_src_reg != pol_pkg::SRC_KEY &&
                                       (new_lo == cur_src_reg || new_hi == cur_src_reg));
      pol_pkg::OFS_SLOW_UP: wr_bad = reg_wdata > 16'(pol_pkg::TIME_MAX);
      pol_pkg::OFS_SLOW_DN: wr_bad = reg_wdata > 16'(pol_pkg::TIME_MAX);
      pol_pkg::OFS_CUR_LIM: wr_bad = reg_wdata != 16'h0000 &&
                                     (reg_wdata < 16'(pol_pkg::CUR_MIN) ||
                                      reg_wdata > 16'(pol_pkg::CUR_MAX));
      pol_pkg::OFS_CUR_SRC: wr_bad = (new_cur != pol_pkg::SRC_KEY &&
                                      cur_lim_reg != 11'h000) ||
                                     (new_cur != pol_pkg::SRC_KEY &&
                                      (new_cur == lo_src_reg || new_cur == hi_src_reg)) ||
                                     (new_cur == pol_pkg::SRC_ADJ3 &&
                                      di_mode != pol_pkg::DI_NONE) ||
                                     (cur_src_reg != pol_pkg::SRC_KEY &&
                                      new_cur != pol_pkg::SRC_KEY && new_cur != cur_src_reg);
      pol_pkg::OFS_HB_THR: wr_bad = reg_wdata > 16'(pol_pkg::HB_MAX);
      pol_pkg::OFS_SU_LIM: wr_bad = reg_wdata > 16'(pol_pkg::PCT_FULL);
      pol_pkg::OFS_SU_TIME: wr_bad = reg_wdata > 16'(pol_pkg::TIME_MAX);
      default: wr_bad = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // accepted writes update the settings; refused ones leave them as they were
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= 8'h00;
      ramp_lo_reg <= pol_pkg::RST_RAMP_LO;
      ramp_hi_reg <= pol_pkg::RST_RAMP_HI;
      lo_src_reg <= pol_pkg::SRC_KEY;
      hi_src_reg <= pol_pkg::SRC_KEY;
      slow_up_reg <= pol_pkg::RST_SLOW;
      slow_dn_reg <= pol_pkg::RST_SLOW;
      cur_lim_reg <= pol_pkg::RST_CUR_LIM;
      cur_src_reg <= pol_pkg::SRC_KEY;
      hb_thr_reg <= pol_pkg::RST_HB_THR;
      do1_reg <= pol_pkg::DO_NONE;
      do2_reg <= pol_pkg::DO_NONE;
      su_lim_reg <= pol_pkg::RST_SU_LIM;
      su_time_reg <= pol_pkg::RST_SU_TIME;
    end else if (reg_wr && !wr_bad) begin
      case (reg_addr)
        pol_pkg::OFS_CTRL: ctrl_reg <= reg_wdata[7:0];
        pol_pkg::OFS_RAMP_LO: ramp_lo_reg <= reg_wdata[9:0];
        pol_pkg::OFS_RAMP_HI: ramp_hi_reg <= reg_wdata[9:0];
        pol_pkg::OFS_RAMP_SRC: begin
          lo_src_reg <= new_lo;
          hi_src_reg <= new_hi;
        end
        pol_pkg::OFS_SLOW_UP: slow_up_reg <= reg_wdata[9:0];
        pol_pkg::OFS_SLOW_DN: slow_dn_reg <= reg_wdata[9:0];
        pol_pkg::OFS_CUR_LIM: cur_lim_reg <= reg_wdata[10:0];
        pol_pkg::OFS_CUR_SRC: cur_src_reg <= new_cur;
        pol_pkg::OFS_HB_THR: hb_thr_reg <= reg_wdata[9:0];
        pol_pkg::OFS_DO1: do1_reg <= reg_wdata[1:0];
        pol_pkg::OFS_DO2: do2_reg <= reg_wdata[1:0];
        pol_pkg::OFS_SU_LIM: su_lim_reg <= reg_wdata[9:0];
        pol_pkg::OFS_SU_TIME: su_time_reg <= reg_wdata[9:0];
        default: ;
      endcase
    end
  end

  // sticky refusal flag; a new refusal wins over the clearing read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reject_reg <= 1'b0;
    end else if (reg_wr && wr_bad) begin
      reject_reg <= 1'b1;
    end else if (reg_rd && reg_addr == pol_pkg::OFS_STATUS) begin
      reject_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 16'h0000;
    end else begin
      case (reg_addr)
        pol_pkg::OFS_CTRL: reg_rdata <= {8'h00, ctrl_reg};
        pol_pkg::OFS_RAMP_LO: reg_rdata <= {6'h00, ramp_lo_reg};
        pol_pkg::OFS_RAMP_HI: reg_rdata <= {6'h00, ramp_hi_reg};
        pol_pkg::OFS_RAMP_SRC: reg_rdata <= {12'h000, hi_src_reg, lo_src_reg};
        pol_pkg::OFS_SLOW_UP: reg_rdata <= {6'h00, slow_up_reg};
        pol_pkg::OFS_SLOW_DN: reg_rdata <= {6'h00, slow_dn_reg};
        pol_pkg::OFS_CUR_LIM: reg_rdata <= {5'h00, cur_lim_reg};
        pol_pkg::OFS_CUR_SRC: reg_rdata <= {14'h0000, cur_src_reg};
        pol_pkg::OFS_HB_THR: reg_rdata <= {6'h00, hb_thr_reg};
        pol_pkg::OFS_DO1: reg_rdata <= {14'h0000, do1_reg};
        pol_pkg::OFS_DO2: reg_rdata <= {14'h0000, do2_reg};
        pol_pkg::OFS_SU_LIM: reg_rdata <= {6'h00, su_lim_reg};
        pol_pkg::OFS_SU_TIME: reg_rdata <= {6'h00, su_time_reg};
        pol_pkg::OFS_STATUS: reg_rdata <= {10'h000, reject_reg, su_active_reg,
                                           cur_limit_active, hb_alarm, manual_active, run_cmd};
        pol_pkg::OFS_LEVEL: reg_rdata <= {6'h00, slew_level};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // demand shaping
  // ----------------------------------------------------------------
  // effective ramp limits, current limit and manual request
  always_comb begin
    lo_eff = ramp_lo_reg;
    hi_eff = ramp_hi_reg;
    if (lo_src_reg != pol_pkg::SRC_KEY) begin
      lo_eff = pct_mul(ramp_lo_reg, adj_pick(lo_src_reg, first_external_adjuster,
                       second_external_adjuster, third_external_adjuster));
    end
    if (hi_src_reg != pol_pkg::SRC_KEY) begin
      hi_eff = pct_mul(ramp_hi_reg, adj_pick(hi_src_reg, first_external_adjuster,
                       second_external_adjuster, third_external_adjuster));
    end
    if (cur_src_reg == pol_pkg::SRC_KEY) begin
      lim_eff = cur_lim_reg;
    end else begin
      lim_eff = pol_pkg::CUR_MIN + 11'(pct_mul(10'h384, adj_pick(cur_src_reg,
                first_external_adjuster, second_external_adjuster,
                third_external_adjuster)));
    end
    lim_on = (cur_lim_reg != 11'h000 || cur_src_reg != pol_pkg::SRC_KEY) &&
             !ctrl_reg[pol_pkg::CTRL_ZVS];
    over_lim = lim_on && load_current > lim_eff;
    case (di_mode)
      pol_pkg::DI_ON: manual_now = di_sync_reg;
      pol_pkg::DI_OFF: manual_now = ~di_sync_reg;
      default: manual_now = 1'b0;
    endcase
    manual_now = manual_now && !ctrl_reg[pol_pkg::CTRL_KEY_MAN];
    hb_now = run_cmd && 16'(load_ratio) < 16'(hb_thr_reg) * 16'h000a;
  end

  // target for the slew limiter
  always_comb begin
    target = demand;
    if (ctrl_reg[pol_pkg::CTRL_AUX_EN]) begin
      target = pct_mul(demand, aux_in);
    end
    if (manual_now) begin
      target = third_external_adjuster;
    end
    if (hi_eff < target) begin
      target = hi_eff;
    end
    if (target < lo_eff) begin
      target = lo_eff;
    end
    if (ctrl_reg[pol_pkg::CTRL_SU_EN] && su_active_reg && target > su_lim_reg) begin
      target = su_lim_reg;
    end
    if (over_lim && slew_level != 10'h000 && target >= slew_level) begin
      target = slew_level - 10'h001;
    end
    if (!run_cmd) begin
      target = 10'h000;
    end
  end

  // rate limiting of the output
  pol_slew u_slew (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick_reg),
    .target(target),
    .up_time(slow_up_reg),
    .dn_time(slow_dn_reg),
    .level(slew_level)
  );

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // status outputs and digital output mapping
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_level <= 10'h000;
      cur_limit_active <= 1'b0;
      hb_alarm <= 1'b0;
      manual_active <= 1'b0;
      first_digital_output <= 1'b0;
      second_digital_output <= 1'b0;
    end else begin
      out_level <= slew_level;
      cur_limit_active <= over_lim;
      hb_alarm <= hb_now;
      manual_active <= manual_now;
      first_digital_output <= do_pick(do1_reg, run_cmd, hb_alarm);
      second_digital_output <= do_pick(do2_reg, run_cmd, hb_alarm);
    end
  end
endmodule // pol_top
